// ---- core/asu_params.svh ----
// Constants for the synchronous action unit: offsets, codes, bits, rates
`ifndef ASU_PARAMS_SVH
`define ASU_PARAMS_SVH

// Clock period and derived rate in hertz
`define ASU_CLK_PERIOD_NS 32'd4
`define ASU_CLK_HZ (32'd1000000000 / `ASU_CLK_PERIOD_NS)

// Range numerator: range 800,000 gives multiplier 10
`define ASU_RANGE_NUM 32'd8000000
`define ASU_ACC_UNIT 32'd125
`define ASU_RST_RANGE 32'h0

// AXI4-Lite byte offsets
`define ASU_OFF_CMD 8'h00
`define ASU_OFF_DLW 8'h04
`define ASU_OFF_DHW 8'h08
`define ASU_OFF_DLR 8'h0C
`define ASU_OFF_DHR 8'h10
`define ASU_OFF_EVT 8'h14
`define ASU_RESP_OKAY 2'h0
`define ASU_RESP_SLVERR 2'h2

// Command word layout and codes
`define ASU_CMD_SEL_LO 8
`define ASU_CMD_RANGE 8'h00
`define ASU_CMD_ACCEL 8'h02
`define ASU_CMD_SSPD 8'h04
`define ASU_CMD_DSPD 8'h05
`define ASU_CMD_COUNT 8'h06
`define ASU_CMD_LPSET 8'h09
`define ASU_CMD_CAPRD 8'h14
`define ASU_CMD_FDRVP 8'h20
`define ASU_CMD_FDRVM 8'h21
`define ASU_CMD_CDRVP 8'h22
`define ASU_CMD_CDRVM 8'h23
`define ASU_CMD_SYNC 8'h64

// Trigger word bits
`define ASU_TRG_DEND 5
`define ASU_TRG_IN3F 7
`define ASU_TRG_NEXT 13
`define ASU_TRG_NEXT2 14

// Action word bits
`define ASU_ACT_FDRVP 0
`define ASU_ACT_OPSET 1
`define ASU_ACT_LPSAV 6
`define ASU_ACT_FDRVM 10
`define ASU_ACT_INT 15

`endif

// ---- core/asu_pkg.sv ----
// Types shared by the synchronous action unit modules
package asu_pkg;

	typedef enum logic [1:0] {ASU_IDLE, ASU_FIXED, ASU_CONT} asu_drv_t;

	typedef struct packed {
		logic [31:0] rng;
		logic [31:0] acc;
		logic [31:0] sv;
		logic [31:0] dv;
		logic [31:0] cnt;
		logic [31:0] left;
		logic [31:0] lp;
		logic [31:0] rate;
		logic [31:0] vacc;
		logic [31:0] racc;
		asu_drv_t st;
		logic minus;
		logic pulse;
		logic dend;
	} asu_axis_st_t;

	typedef struct packed {
		logic [15:0] tw;
		logic [15:0] aw;
		logic in3_d;
		logic trig;
	} asu_sync_st_t;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic cmd_go;
		logic [15:0] cmd;
		logic [15:0] dlw;
		logic [15:0] dhw;
		logic [15:0] dlr;
		logic [15:0] dhr;
		logic [2:0] flags;
		logic [2:0][31:0] cap;
		logic irq;
	} asu_top_st_t;

endpackage

// ---- core/asu_axis_drive.sv ----
// One axis: speed parameters, pulse generator and logical position counter
`timescale 1ns/1ps
`include "asu_params.svh"
module asu_axis_drive
	import asu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Parameter writes
	input wire logic range_wr,
	input wire logic accel_wr,
	input wire logic sspd_wr,
	input wire logic dspd_wr,
	input wire logic count_wr,
	input wire logic lp_wr,
	input wire logic [31:0] wr_data,
	// Drive start
	input wire logic start_req,
	input wire logic start_fixed,
	input wire logic start_minus,
	// Stop inputs
	input wire logic plus_limit,
	input wire logic emg_stop,
	// Axis state
	output logic [31:0] lp,
	output logic busy,
	output logic drive_end,
	output logic pulse,
	output logic minus
);
	asu_axis_st_t s_reg, s_next;
	logic [31:0] mult, v_start, v_drive, v_acc, vsum, rsum, new_left;

	assign mult = (s_reg.rng == 32'h0) ? 32'h1 : `ASU_RANGE_NUM / s_reg.rng;
	assign v_acc = s_reg.acc * `ASU_ACC_UNIT * mult;
	assign v_start = s_reg.sv * mult;
	assign v_drive = s_reg.dv * mult;
	assign vsum = s_reg.vacc + s_reg.rate;
	assign rsum = s_reg.racc + v_acc;
	// A count loaded in the start cycle is the one used
	assign new_left = count_wr ? wr_data : s_reg.cnt;

	// Parameter loads, start, DDA pulse rate and linear ramp up
	always_comb begin
		s_next = s_reg;
		s_next.pulse = 1'b0;
		s_next.dend = 1'b0;
		if (range_wr) s_next.rng = wr_data;
		if (accel_wr) s_next.acc = wr_data;
		if (sspd_wr) s_next.sv = wr_data;
		if (dspd_wr) s_next.dv = wr_data;
		if (count_wr) s_next.cnt = wr_data;
		if (lp_wr) s_next.lp = wr_data;
		case (s_reg.st)
			ASU_IDLE: begin
				if (start_req && !(start_fixed && new_left == 32'h0)) begin
					s_next.st = start_fixed ? ASU_FIXED : ASU_CONT;
					s_next.minus = start_minus;
					s_next.left = new_left;
					s_next.rate = v_start;
					s_next.vacc = 32'h0;
					s_next.racc = 32'h0;
				end
			end
			ASU_FIXED, ASU_CONT: begin
				if (emg_stop || (plus_limit && !s_reg.minus)) begin
					s_next.st = ASU_IDLE;
					s_next.dend = 1'b1;
				end else begin
					if (rsum >= `ASU_CLK_HZ) begin
						s_next.racc = rsum - `ASU_CLK_HZ;
						if (s_reg.rate < v_drive) s_next.rate = s_reg.rate + 32'h1;
					end else begin
						s_next.racc = rsum;
					end
					if (vsum >= `ASU_CLK_HZ) begin
						s_next.vacc = vsum - `ASU_CLK_HZ;
						s_next.pulse = 1'b1;
						s_next.lp = s_reg.minus ? s_reg.lp - 32'h1 : s_reg.lp + 32'h1;
						if (s_reg.st == ASU_FIXED) begin
							s_next.left = s_reg.left - 32'h1;
							if (s_reg.left == 32'h1) begin
								s_next.st = ASU_IDLE;
								s_next.dend = 1'b1;
							end
						end
					end else begin
						s_next.vacc = vsum;
					end
				end
			end
			default: s_next.st = ASU_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) s_reg <= '0;
		else s_reg <= s_next;
	end

	assign lp = s_reg.lp;
	assign busy = (s_reg.st != ASU_IDLE);
	assign drive_end = s_reg.dend;
	assign pulse = s_reg.pulse;
	assign minus = s_reg.minus;
endmodule

// ---- core/asu_sync_unit.sv ----
// One axis: synchronous mode words and trigger detection
`timescale 1ns/1ps
`include "asu_params.svh"
module asu_sync_unit
	import asu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Mode write
	input wire logic mode_wr,
	input wire logic [31:0] mode_data,
	// Trigger sources
	input wire logic in3,
	input wire logic drive_end,
	input wire logic ext_start,
	// Results
	output logic trig,
	output logic go,
	output logic [15:0] trig_word,
	output logic [15:0] act_word
);
	asu_sync_st_t s_reg, s_next;

	// Trigger detect; a fresh mode write replaces both words
	always_comb begin
		s_next = s_reg;
		s_next.in3_d = in3;
		s_next.trig = (s_reg.tw[`ASU_TRG_IN3F] & s_reg.in3_d & ~in3) |
			(s_reg.tw[`ASU_TRG_DEND] & drive_end);
		if (mode_wr) begin
			s_next.tw = mode_data[15:0];
			s_next.aw = mode_data[31:16];
		end
	end

	// State register; in3_d clears so reset cannot fake an edge
	always_ff @(posedge aclk) begin
		if (!aresetn) s_reg <= '0;
		else s_reg <= s_next;
	end

	assign trig = s_reg.trig;
	assign go = s_reg.trig | ext_start;
	assign trig_word = s_reg.tw;
	assign act_word = s_reg.aw;
endmodule

// ---- core/asu_sync_action.sv ----
// Synchronous action unit top: AXI4-Lite registers, commands, three axes
// How it works
// - Bits 8..10 select axes; command 09h loads position counter.
// - Command 02h acceleration rate is value times 125 times multiplier.
// - Command 04h start rate is value times multiplier.
// - Command 05h drive rate is value times multiplier.
// - Command 00h sets range; 800,000 gives multiplier 10.
// - Command 64h trigger 6080h: input falling edge, starts other axes.
// - Action 0040h copies position counter into capture buffer on trigger.
// - Action 8040h saves position and raises the interrupt.
// - Input trigger during drive saves each configured axis position.
// - Interrupt leaves on one active low output.
// - Event status register flags a synchronous operation interrupt.
// - Command 22h starts plus continuous drive on selected axes.
// - Command 20h starts plus fixed drive of preset pulse count.
// - Trigger 0020h fires on the axis's own drive end.
// - Action 8402h loads count, starts minus fixed drive, interrupts.
// - Drive end trigger with start action chains the next drive.
// - Drive ended by limit or emergency still fires the chain.
`timescale 1ns/1ps
`include "asu_params.svh"
module asu_sync_action
	import asu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Axis inputs, bit 0 is X
	input wire logic [2:0] x_general_input_three,
	input wire logic [2:0] plus_limit_input,
	input wire logic emergency_stop_input,
	// Axis outputs
	output logic [2:0] drive_pulse,
	output logic [2:0] drive_minus,
	// Interrupt
	output logic interrupt_request_n
);
	asu_top_st_t s_reg, s_next;

	// Command decode of the word issued last cycle
	logic cg;
	logic [7:0] code;
	logic [2:0] sel;
	logic [31:0] data_pair;

	// Per axis wiring
	logic [2:0][31:0] lp;
	logic [2:0] busy;
	logic [2:0] dend;
	logic [2:0] trig;
	logic [2:0] go;
	logic [2:0] ext;
	logic [2:0][15:0] tw;
	logic [2:0][15:0] aw;

	// Flag set and clear terms
	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	// Byte lane merge for 16-bit data registers
	function automatic logic [15:0] asu_merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		asu_merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	assign cg = s_reg.cmd_go;
	assign code = s_reg.cmd[7:0];
	assign sel = s_reg.cmd[`ASU_CMD_SEL_LO +: 3];
	assign data_pair = {s_reg.dhw, s_reg.dlw};

	// One drive and one sync unit per axis
	for (genvar g = 0; g < 3; g++) begin : g_axis
		localparam int PREV = (g + 2) % 3;
		localparam int PREV2 = (g + 1) % 3;
		logic hit;
		logic cmd_start;
		logic act_start;
		logic start_fixed;
		logic start_minus;

		assign hit = cg & sel[g];
		assign cmd_start = hit & ((code == `ASU_CMD_FDRVP) | (code == `ASU_CMD_FDRVM) |
			(code == `ASU_CMD_CDRVP) | (code == `ASU_CMD_CDRVM));
		assign act_start = go[g] & (aw[g][`ASU_ACT_FDRVP] | aw[g][`ASU_ACT_FDRVM]);
		assign start_fixed = act_start | (code == `ASU_CMD_FDRVP) |
			(code == `ASU_CMD_FDRVM);
		assign start_minus = act_start ? aw[g][`ASU_ACT_FDRVM] :
			((code == `ASU_CMD_FDRVM) | (code == `ASU_CMD_CDRVM));
		assign ext[g] = (trig[PREV] & tw[PREV][`ASU_TRG_NEXT]) |
			(trig[PREV2] & tw[PREV2][`ASU_TRG_NEXT2]);

		asu_axis_drive u_drive (
			.aclk(aclk),
			.aresetn(aresetn),
			.range_wr(hit & (code == `ASU_CMD_RANGE)),
			.accel_wr(hit & (code == `ASU_CMD_ACCEL)),
			.sspd_wr(hit & (code == `ASU_CMD_SSPD)),
			.dspd_wr(hit & (code == `ASU_CMD_DSPD)),
			.count_wr((hit & (code == `ASU_CMD_COUNT)) | (go[g] & aw[g][`ASU_ACT_OPSET])),
			.lp_wr(hit & (code == `ASU_CMD_LPSET)),
			.wr_data(data_pair),
			.start_req(cmd_start | act_start),
			.start_fixed(start_fixed),
			.start_minus(start_minus),
			.plus_limit(plus_limit_input[g]),
			.emg_stop(emergency_stop_input),
			.lp(lp[g]),
			.busy(busy[g]),
			.drive_end(dend[g]),
			.pulse(drive_pulse[g]),
			.minus(drive_minus[g])
		);

		asu_sync_unit u_sync (
			.aclk(aclk),
			.aresetn(aresetn),
			.mode_wr(hit & (code == `ASU_CMD_SYNC)),
			.mode_data(data_pair),
			.in3(x_general_input_three[g]),
			.drive_end(dend[g]),
			.ext_start(ext[g]),
			.trig(trig[g]),
			.go(go[g]),
			.trig_word(tw[g]),
			.act_word(aw[g])
		);

		assign flag_set[g] = go[g] & aw[g][`ASU_ACT_INT];
	end

	// Bus slave, command issue, capture buffers and event flags
	always_comb begin
		s_next = s_reg;
		s_next.cmd_go = 1'b0;
		flag_clr = 3'h0;

		// Write response retires before a new write can complete
		if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_got = 1'b1;
			s_next.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end

		// Address and data both held: perform the write
		if (s_reg.aw_got && s_reg.w_got) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `ASU_RESP_OKAY;
			case (s_reg.waddr)
				`ASU_OFF_CMD: begin
					s_next.cmd = asu_merge(s_reg.cmd, s_reg.wdata, s_reg.wstrb);
					s_next.cmd_go = 1'b1;
				end
				`ASU_OFF_DLW: s_next.dlw = asu_merge(s_reg.dlw, s_reg.wdata, s_reg.wstrb);
				`ASU_OFF_DHW: s_next.dhw = asu_merge(s_reg.dhw, s_reg.wdata, s_reg.wstrb);
				default: s_next.bresp = `ASU_RESP_SLVERR;
			endcase
		end

		// Read channel, one outstanding read
		if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `ASU_RESP_OKAY;
			case (s_axi_araddr)
				`ASU_OFF_CMD: s_next.rdata = {16'h0000, s_reg.cmd};
				`ASU_OFF_DLW: s_next.rdata = {16'h0000, s_reg.dlw};
				`ASU_OFF_DHW: s_next.rdata = {16'h0000, s_reg.dhw};
				`ASU_OFF_DLR: s_next.rdata = {16'h0000, s_reg.dlr};
				`ASU_OFF_DHR: s_next.rdata = {16'h0000, s_reg.dhr};
				`ASU_OFF_EVT: begin
					s_next.rdata = {25'h0000000, busy, 1'b0, s_reg.flags};
					flag_clr = s_reg.flags;
				end
				default: begin
					s_next.rdata = 32'h00000000;
					s_next.rresp = `ASU_RESP_SLVERR;
				end
			endcase
		end

		// Capture buffer: a trigger in the read cycle still lands
		for (int a = 0; a < 3; a++) begin
			if (go[a] && aw[a][`ASU_ACT_LPSAV]) s_next.cap[a] = lp[a];
		end

		for (int a = 2; a >= 0; a--) begin
			if (cg && sel[a] && code == `ASU_CMD_CAPRD) begin
				s_next.dlr = s_reg.cap[a][15:0];
				s_next.dhr = s_reg.cap[a][31:16];
			end
		end

		// Read clears reported flags; a new event the same cycle wins
		s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;
		s_next.irq = |s_next.flags;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) s_reg <= '0;
		else s_reg <= s_next;
	end

	// Handshake outputs; a pending response blocks further writes
	assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
	assign s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
	assign s_axi_arready = ~s_reg.rvalid;

	// Registered answers
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;

	assign interrupt_request_n = ~s_reg.irq;
endmodule

// ---- tb/asu_host_model.sv ----
// Host processor model: AXI4-Lite register writes, reads and command sequences
`timescale 1ns/1ps
`include "asu_params.svh"
module asu_host_model (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// One write; payload is scrambled once taken so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// One read; waits as long as the slave needs
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic put(input logic [31:0] d);
		logic [1:0] r;
		wr(`ASU_OFF_DLW, {16'h0000, d[15:0]}, r);
		wr(`ASU_OFF_DHW, {16'h0000, d[31:16]}, r);
	endtask

	task automatic cmd(input logic [15:0] c, input logic [31:0] d);
		logic [1:0] r;
		put(d);
		wr(`ASU_OFF_CMD, {16'h0000, c}, r);
	endtask
endmodule

// ---- tb/asu_sync_action_properties.sv ----
// Bus handshake, interrupt and stop checks on the action unit ports
`timescale 1ns/1ps
module asu_sync_action_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Axis side
	input wire logic [2:0] plus_limit_input,
	input wire logic emergency_stop_input,
	input wire logic [2:0] drive_pulse,
	input wire logic [2:0] drive_minus,
	input wire logic interrupt_request_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken while answering");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_irq_clr;
		$rose(interrupt_request_n) |-> s_axi_rvalid || $past(s_axi_rvalid);
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt released without read");
	property p_emg;
		emergency_stop_input [*3] |-> drive_pulse == 3'h0;
	endproperty
	a_emg: assert property (p_emg) else $error("pulse during emergency stop");
	property p_lim;
		plus_limit_input[0] [*3] ##0 !drive_minus[0] |-> !drive_pulse[0];
	endproperty
	a_lim: assert property (p_lim) else $error("plus pulse at limit");

	// Main scenarios reached
	c_irq: cover property (!interrupt_request_n);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_minus: cover property (drive_pulse[0] && drive_minus[0]);
endmodule

bind asu_sync_action asu_sync_action_checker u_asu_sync_action_checker (.*);

// ---- tb/asu_sync_action_tb.sv ----
// Bench: register access, input-triggered position saves and chained drives
`timescale 1ns/1ps
`include "asu_params.svh"
module asu_sync_action_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, lo, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic interrupt_request_n, emergency_stop_input = 1'b0;
	logic [2:0] x_general_input_three = 3'h7, plus_limit_input = 3'h0;
	logic [2:0] drive_pulse, drive_minus;
	int pos[3] = '{0, 0, 0}, np[3] = '{0, 0, 0}, nm[3] = '{0, 0, 0}, snap[3];
	int cyc = 0, last_t = 0, gap = 0, p0, m0, n_errors = 0, cmp_count = 0;
	integer seed = 32'hD20EF640;

	asu_sync_action u_asu_sync_action (.*);
	asu_host_model u_asu_host_model (.*);

	always #2 aclk = ~aclk;

	// Position model: one count per pulse, sign from direction
	always @(posedge aclk) begin
		cyc++;
		for (int i = 0; i < 3; i++) if (drive_pulse[i] === 1'b1) begin
			if (drive_minus[i]) begin
				pos[i]--;
				nm[i]++;
			end else begin
				pos[i]++;
				np[i]++;
			end
			if (i == 0) begin
				gap = cyc - last_t;
				last_t = cyc;
			end
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: response %h expected %h", $time, got, exp);
		end
	endtask

	task final_report;
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog at 50,000 cycles, well beyond the expected run of under a thousand cycles
	initial begin
		#200000;
		n_errors++;
		final_report;
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		u_asu_host_model.rd(`ASU_OFF_EVT, d, r);
		chk(d, 32'h0);
		chk(interrupt_request_n, 1'b1);
		u_asu_host_model.rd(8'h18, d, r);
		chk_resp(r, `ASU_RESP_SLVERR);
		u_asu_host_model.wr(`ASU_OFF_DLR, 32'h5A5A, r);
		chk_resp(r, `ASU_RESP_SLVERR);
		$display("test bus done");
		// Rate 2625A0h times 10 gives one pulse every 10 clocks
		u_asu_host_model.cmd(16'h0700, 32'h000C3500);
		u_asu_host_model.cmd(16'h0702, 32'h00000190);
		u_asu_host_model.cmd(16'h0704, 32'h002625A0);
		u_asu_host_model.cmd(16'h0705, 32'h002625A0);
		v = $random(seed);
		u_asu_host_model.cmd(16'h0709, v);
		@(posedge aclk);
		pos = '{v, v, v};
		u_asu_host_model.cmd(16'h0164, 32'h80406080);
		u_asu_host_model.cmd(16'h0664, 32'h00400000);
		u_asu_host_model.cmd(16'h0722, 32'h0);
		repeat (60) @(posedge aclk);
		chk(gap, 32'hA);
		// Trigger just after a pulse so no count is in flight
		do @(posedge aclk); while (drive_pulse[0] !== 1'b1);
		x_general_input_three <= 3'h6;
		@(posedge aclk);
		snap = pos;
		repeat (3) @(posedge aclk);
		chk(interrupt_request_n, 1'b0);
		u_asu_host_model.rd(`ASU_OFF_EVT, d, r);
		chk(d, 32'h71);
		u_asu_host_model.rd(`ASU_OFF_EVT, d, r);
		chk(d, 32'h70);
		chk(interrupt_request_n, 1'b1);
		for (int i = 0; i < 3; i++) begin
			u_asu_host_model.cmd(16'h0014 | (16'h0100 << i), 32'h0);
			u_asu_host_model.rd(`ASU_OFF_DLR, lo, r);
			u_asu_host_model.rd(`ASU_OFF_DHR, d, r);
			chk({d[15:0], lo[15:0]}, snap[i]);
		end
		$display("test input save done");
		emergency_stop_input <= 1'b1;
		repeat (5) @(posedge aclk);
		p0 = np[0] + np[1] + np[2];
		repeat (30) @(posedge aclk);
		chk(np[0] + np[1] + np[2], p0);
		emergency_stop_input <= 1'b0;
		x_general_input_three <= 3'h7;
		u_asu_host_model.cmd(16'h0764, 32'h0);
		$display("test stop done");
		// Second pass ends the first drive at the plus limit
		for (int k = 0; k < 2; k++) begin
			u_asu_host_model.cmd(16'h0106, k ? 32'h64 : 32'h7);
			u_asu_host_model.cmd(16'h0164, 32'h84020020);
			u_asu_host_model.put(32'h5);
			p0 = np[0];
			m0 = nm[0];
			u_asu_host_model.wr(`ASU_OFF_CMD, 32'h0120, r);
			if (k) begin
				repeat (40) @(posedge aclk);
				plus_limit_input <= 3'h1;
			end
			do @(posedge aclk); while (drive_minus[0] !== 1'b1);
			// clear before the chained drive ends
			u_asu_host_model.cmd(16'h0164, 32'h0);
			repeat (100) @(posedge aclk);
			plus_limit_input <= 3'h0;
			chk(nm[0] - m0, 32'h5);
			if (!k)
				chk(np[0] - p0, 32'h7);
			chk(interrupt_request_n, 1'b0);
			u_asu_host_model.rd(`ASU_OFF_EVT, d, r);
			chk(d, 32'h1);
			$display("test chained drive %0d done", k);
		end
		final_report;
	end
endmodule
